// ---- core/ufc_fifo.sv ----
// byte queue with flush and a run-time capacity limit
`timescale 1ns/1ps
module ufc_fifo
   import ufc_pkg::*;
#(
   parameter int DEPTH = 16
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   ufc_fifo_if.store q
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin : g_bad_depth
         $error("ufc_fifo depth must be a power of two of at least two");
      end
   endgenerate
   ufc_byte_t mem [DEPTH];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0] count_r, count_nxt;
   logic push_ok, pop_ok;
   assign q.full = (count_r >= q.cap);
   assign q.empty = (count_r == '0);
   assign q.count = count_r;
   assign q.rdata = mem[rd_ptr_r];
   assign push_ok = q.push && !q.full && !q.flush;
   assign pop_ok = q.pop && !q.empty && !q.flush;
   always_comb
   begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      if (q.flush)
      begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
         count_nxt = '0;
      end
      else
      begin
         if (push_ok)
            wr_ptr_nxt = wr_ptr_r + AW'(1);
         if (pop_ok)
            rd_ptr_nxt = rd_ptr_r + AW'(1);
         if (push_ok && !pop_ok)
            count_nxt = count_r + CW'(1);
         else if (pop_ok && !push_ok)
            count_nxt = count_r - CW'(1);
      end
   end
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else if (clk_en)
      begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (clk_en && push_ok)
         mem[wr_ptr_r] <= q.push_data;
   end
endmodule : ufc_fifo

// ---- core/ufc_fifo_if.sv ----
// signals between the control logic and one byte queue
`timescale 1ns/1ps
interface ufc_fifo_if #(parameter int DEPTH = 16);
   localparam int CW = $clog2(DEPTH) + 1;
   logic push;
   logic [7:0] push_data;
   logic pop;
   logic [7:0] rdata;
   logic flush;
   logic [CW-1:0] cap;
   logic [CW-1:0] count;
   logic full;
   logic empty;
   modport ctrl (output push, push_data, pop, flush, cap, input rdata, count, full, empty);
   modport store (input push, push_data, pop, flush, cap, output rdata, count, full, empty);
endinterface : ufc_fifo_if

// ---- core/ufc_params.svh ----
// constants for the uart fifo control block
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
`define UFC_ADDR_W 3
`define UFC_OFS_CTRL 3'h0
`define UFC_OFS_DATA 3'h1
`define UFC_OFS_RXFILL 3'h2
`define UFC_OFS_STAT 3'h3
`define UFC_OFS_MASK 3'h4
`define UFC_OFS_TXFILL 3'h5
`define UFC_BIT_EN 0
`define UFC_BIT_RXCLR 1
`define UFC_BIT_TXCLR 2
`define UFC_BIT_DMA 3
`define UFC_CTRL_RESET 8'h00
`define UFC_STAT_RESET 4'h0
`define UFC_MASK_RESET 4'h0
`define UFC_FIFO_DEPTH 16
`define UFC_TRIG_L0 5'h01
`define UFC_TRIG_L1 5'h04
`define UFC_TRIG_L2 5'h08
`define UFC_TRIG_L3 5'h0e
`define UFC_EV_RXTRIG 0
`define UFC_EV_TXSPACE 1
`define UFC_EV_TIMEOUT 2
`define UFC_EV_OVERRUN 3
`define UFC_EV_N 4
`endif

// ---- core/ufc_pkg.sv ----
// types for the uart fifo control block
package ufc_pkg;
   typedef enum logic [1:0]
   {
      UFC_RXB_IDLE = 2'b01,
      UFC_RXB_HELD = 2'b10
   } ufc_rxb_t;
   typedef logic [7:0] ufc_byte_t;
endpackage : ufc_pkg

// ---- core/ufc_top.sv ----
// fifo control, dma ready pins and event flags of one uart channel
`timescale 1ns/1ps
`include "ufc_params.svh"
module ufc_top
   import ufc_pkg::*;
#(
   parameter int DEPTH = `UFC_FIFO_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [`UFC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic tx_take,
   output logic [7:0] tx_char,
   output logic tx_char_valid,
   input wire logic rx_load,
   input wire logic [7:0] rx_char,
   input wire logic rx_timeout,
   output logic rx_room,
   output logic tx_ready_pin_n,
   output logic rx_ready_pin_n,
   output logic rx_data_int,
   output logic tx_int,
   output logic irq
);
   localparam int CW = $clog2(DEPTH) + 1;
   generate
      if (DEPTH < 14)
      begin : g_bad_depth
         $error("ufc_top depth must hold the highest trigger level");
      end
   endgenerate

   function automatic logic [4:0] ufc_level(input logic [1:0] sel);
      logic [4:0] lv;
      lv = `UFC_TRIG_L0;
      unique case (sel)
         2'b00: lv = `UFC_TRIG_L0;
         2'b01: lv = `UFC_TRIG_L1;
         2'b10: lv = `UFC_TRIG_L2;
         2'b11: lv = `UFC_TRIG_L3;
      endcase
      return lv;
   endfunction : ufc_level

   ufc_fifo_if #(.DEPTH(DEPTH)) tx_q ();
   ufc_fifo_if #(.DEPTH(DEPTH)) rx_q ();

   ufc_fifo #(.DEPTH(DEPTH)) u_tx_fifo
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .q(tx_q)
   );
   ufc_fifo #(.DEPTH(DEPTH)) u_rx_fifo
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .q(rx_q)
   );

   logic [7:0] fifo_control_reg, ctrl_nxt;
   logic [`UFC_EV_N-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
   logic [7:0] rdata_r, rdata_nxt;
   logic rx_int_r, tx_int_r;
   ufc_rxb_t rxb_r, rxb_nxt;
   logic wr_ctrl, fifo_enable_bit, dma_mode_select, mode1;
   logic [1:0] rx_trigger_select;
   logic [4:0] receive_threshold;
   logic [CW-1:0] lvl;
   logic rx_lvl_hit, rx_push_ok;

   assign wr_ctrl = reg_wr && (reg_addr == `UFC_OFS_CTRL);
   assign fifo_enable_bit = fifo_control_reg[`UFC_BIT_EN];
   assign dma_mode_select = fifo_control_reg[`UFC_BIT_DMA];
   assign rx_trigger_select = fifo_control_reg[7:6];
   assign receive_threshold = ufc_level(rx_trigger_select);
   assign lvl = CW'(receive_threshold);
   assign mode1 = fifo_enable_bit && dma_mode_select;

   // queue wiring; with fifos off each queue acts as a one-byte holding register
   assign tx_q.cap = fifo_enable_bit ? CW'(DEPTH) : CW'(1);
   assign rx_q.cap = fifo_enable_bit ? CW'(DEPTH) : CW'(1);
   assign tx_q.push = reg_wr && (reg_addr == `UFC_OFS_DATA);
   assign tx_q.push_data = reg_wdata;
   assign tx_q.pop = tx_take;
   assign tx_q.flush = fifo_control_reg[`UFC_BIT_TXCLR];
   assign rx_q.push = rx_load;
   assign rx_q.push_data = rx_char;
   assign rx_q.pop = reg_rd && (reg_addr == `UFC_OFS_DATA);
   assign rx_q.flush = fifo_control_reg[`UFC_BIT_RXCLR];
   assign rx_push_ok = rx_load && !rx_q.full && !rx_q.flush;
   assign tx_char = tx_q.rdata;
   assign tx_char_valid = !tx_q.empty;
   assign rx_room = !rx_q.full;
   assign rx_lvl_hit = fifo_enable_bit && (rx_q.count == lvl);

   // control register: clear bits last one cycle, writes gated by enable
   always_comb
   begin
      ctrl_nxt = fifo_control_reg;
      ctrl_nxt[`UFC_BIT_TXCLR] = 1'b0;
      ctrl_nxt[`UFC_BIT_RXCLR] = 1'b0;
      if (wr_ctrl)
      begin
         if (reg_wdata[`UFC_BIT_EN])
            ctrl_nxt = {reg_wdata[7:6], 2'b00, reg_wdata[3:1], 1'b1};
         else
            ctrl_nxt[`UFC_BIT_EN] = 1'b0;
      end
   end

   // sticky event flags, set wins over a write-one clear
   always_comb
   begin
      ev = '0;
      ev[`UFC_EV_RXTRIG] = rx_data_int && !rx_int_r;
      ev[`UFC_EV_TXSPACE] = tx_int && !tx_int_r;
      ev[`UFC_EV_TIMEOUT] = rx_timeout;
      ev[`UFC_EV_OVERRUN] = rx_load && !rx_push_ok;
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      if (reg_wr && (reg_addr == `UFC_OFS_STAT))
         stat_nxt = stat_r & ~reg_wdata[`UFC_EV_N-1:0];
      if (reg_wr && (reg_addr == `UFC_OFS_MASK))
         mask_nxt = reg_wdata[`UFC_EV_N-1:0];
      stat_nxt = stat_nxt | ev;
   end

   // mode 1 receive-ready hold
   always_comb
   begin
      rxb_nxt = rxb_r;
      if (!mode1)
         rxb_nxt = UFC_RXB_IDLE;
      else
      begin
         unique case (rxb_r)
            UFC_RXB_IDLE:
               if (rx_lvl_hit || rx_timeout)
                  rxb_nxt = UFC_RXB_HELD;
            UFC_RXB_HELD:
               if (rx_q.empty && !rx_timeout)
                  rxb_nxt = UFC_RXB_IDLE;
            default:
               rxb_nxt = UFC_RXB_IDLE;
         endcase
      end
   end

   // read data valid only in the cycle after the strobe
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `UFC_OFS_CTRL: rdata_nxt = fifo_control_reg;
            `UFC_OFS_DATA: rdata_nxt = rx_q.rdata;
            `UFC_OFS_RXFILL: rdata_nxt = 8'(rx_q.count);
            `UFC_OFS_STAT: rdata_nxt = 8'(stat_r);
            `UFC_OFS_MASK: rdata_nxt = 8'(mask_r);
            `UFC_OFS_TXFILL: rdata_nxt = 8'(tx_q.count);
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fifo_control_reg <= `UFC_CTRL_RESET;
         stat_r <= `UFC_STAT_RESET;
         mask_r <= `UFC_MASK_RESET;
         rdata_r <= 8'h00;
         rx_int_r <= 1'b0;
         tx_int_r <= 1'b0;
         rxb_r <= UFC_RXB_IDLE;
      end
      else if (clk_en)
      begin
         fifo_control_reg <= ctrl_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         rdata_r <= rdata_nxt;
         rx_int_r <= rx_data_int;
         tx_int_r <= tx_int;
         rxb_r <= rxb_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq = |(stat_r & mask_r);
   // mode 0 pins follow holding state, mode 1 pins follow block state
   assign tx_ready_pin_n = mode1 ? tx_q.full : !tx_q.empty;
   assign rx_ready_pin_n = mode1 ? (rxb_r != UFC_RXB_HELD) : rx_q.empty;
   assign rx_data_int = fifo_enable_bit ? (rx_q.count >= lvl) : !rx_q.empty;
   assign tx_int = mode1 ? !tx_q.full : tx_q.empty;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   AST_TRIG_MAP: assert property (receive_threshold ==
      ((rx_trigger_select == 2'b00) ? 5'h01 : (rx_trigger_select == 2'b01) ? 5'h04 :
      (rx_trigger_select == 2'b10) ? 5'h08 : 5'h0e))
      else $error("trigger level decode wrong");
   AST_RX_INT_EQ: assert property (fifo_enable_bit && rx_q.count == lvl |-> rx_data_int)
      else $error("receive condition missing at trigger level");
   AST_RX_FILL: assert property (clk_en && rx_load && !rx_q.full && !rx_q.pop
      && !rx_q.flush |=> rx_q.count == $past(rx_q.count) + CW'(1))
      else $error("receive character not accepted below full");
   AST_DMA0_TX: assert property (!mode1 |-> tx_ready_pin_n == !tx_q.empty)
      else $error("mode 0 transmit pin wrong");
   AST_DMA0_RX: assert property (!mode1 |-> rx_ready_pin_n == rx_q.empty)
      else $error("mode 0 receive pin wrong");
   AST_DMA1_TX: assert property (mode1 |-> tx_ready_pin_n == (tx_q.count == CW'(DEPTH)))
      else $error("mode 1 transmit pin wrong");
   AST_DMA1_RX: assert property (clk_en && mode1 && (rx_lvl_hit || rx_timeout)
      && !wr_ctrl |=> !rx_ready_pin_n)
      else $error("mode 1 receive pin not low after trigger");
   AST_DMA1_RX_HOLD: assert property (mode1 && !rx_ready_pin_n && !rx_q.empty && clk_en
      && !wr_ctrl |=> !rx_ready_pin_n)
      else $error("mode 1 receive pin released before empty");
   AST_TX_CLR: assert property ((clk_en && wr_ctrl && reg_wdata[2] && reg_wdata[0])
      ##1 clk_en |=> tx_q.count == '0 && !fifo_control_reg[2])
      else $error("transmit clear did not empty or release");
   AST_RX_CLR: assert property ((clk_en && wr_ctrl && reg_wdata[1] && reg_wdata[0])
      ##1 clk_en |=> rx_q.count == '0 && !fifo_control_reg[1])
      else $error("receive clear did not empty or release");
   AST_EN_GATE: assert property (clk_en && wr_ctrl && !reg_wdata[0]
      |=> !fifo_enable_bit && $stable(fifo_control_reg[7:3]))
      else $error("control bits changed without enable");
   AST_UNUSED: assert property (fifo_control_reg[5:4] == 2'b00)
      else $error("unused control bits set");
   AST_RX_INT_DROP: assert property (fifo_enable_bit && rx_q.count < lvl |-> !rx_data_int)
      else $error("receive condition held below trigger");
   AST_TX_INT: assert property (mode1 |-> tx_int == (tx_q.count < CW'(DEPTH)))
      else $error("mode 1 transmit condition wrong");
   AST_DEPTH: assert property (rx_q.count <= CW'(DEPTH) && tx_q.count <= CW'(DEPTH))
      else $error("fill counter beyond depth");
   AST_RESET_CTRL: assert property ($rose(resetn) |->
      fifo_control_reg == `UFC_CTRL_RESET && rxb_r == UFC_RXB_IDLE)
      else $error("control not at reset value after reset");
   AST_CTRL_EN: assert property (clk_en && wr_ctrl && reg_wdata[0]
      |=> fifo_control_reg == ($past(reg_wdata) & 8'hcf))
      else $error("enabled control write not taken");
   AST_TXCLR_ONE: assert property (clk_en && fifo_control_reg[2] && !wr_ctrl
      |=> !fifo_control_reg[2])
      else $error("transmit clear bit did not return to zero");
   AST_RXCLR_ONE: assert property (clk_en && fifo_control_reg[1] && !wr_ctrl
      |=> !fifo_control_reg[1])
      else $error("receive clear bit did not return to zero");
   AST_TX_FLUSH: assert property (clk_en && tx_q.flush |=> tx_q.empty)
      else $error("transmit flush left characters");
   AST_RX_FLUSH: assert property (clk_en && rx_q.flush |=> rx_q.empty)
      else $error("receive flush left characters");
   AST_OFF_HOLD: assert property (!fifo_enable_bit |-> rx_q.full == !rx_q.empty
      && tx_q.full == !tx_q.empty)
      else $error("disabled queue not a one-character holding register");
   AST_CAP: assert property (fifo_enable_bit |-> rx_room == (rx_q.count < CW'(DEPTH))
      && tx_q.full == (tx_q.count == CW'(DEPTH)))
      else $error("enabled queue capacity wrong");
   AST_RX_INT_RISE: assert property (clk_en && fifo_enable_bit && !wr_ctrl && rx_push_ok
      && !rx_q.pop && rx_q.count == lvl - CW'(1) |=> rx_data_int)
      else $error("receive condition missing after reaching trigger");
   AST_EV_RXTRIG: assert property (clk_en && rx_data_int && !rx_int_r |=> stat_r[0])
      else $error("receive condition rise not flagged");
   AST_EV_TMO: assert property (clk_en && rx_timeout |=> stat_r[2])
      else $error("time-out not flagged");
   AST_DMA1_REL: assert property (clk_en && mode1 && rxb_r == UFC_RXB_HELD && rx_q.empty
      && !rx_timeout && !wr_ctrl |=> rx_ready_pin_n)
      else $error("mode 1 receive pin held after queue empty");

   COV_RX_FULL: cover property (fifo_enable_bit && rx_q.full);
   COV_DMA1_RX: cover property (mode1 && !rx_ready_pin_n ##[1:40] rx_ready_pin_n);
   COV_TX_CLR: cover property (fifo_control_reg[2] && !tx_q.empty);
   COV_IRQ: cover property (irq ##1 !irq);
   COV_TMO: cover property (mode1 && rx_timeout && rx_q.count < lvl);
endmodule : ufc_top

// ---- sim/testbench.sv ----
// self-checking bench for the uart fifo control block
`timescale 1ns/1ps
`include "ufc_params.svh"
module testbench
   import ufc_pkg::*;
;
   logic sys_clk, resetn, reg_wr, reg_rd, feed, drain, tmo;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, tx_char, rx_char, sent;
   logic tx_take, tx_char_valid, rx_load, rx_timeout, rx_room;
   logic tx_ready_pin_n, rx_ready_pin_n, rx_data_int, tx_int, irq;
   int errors, comparisons;
   logic [7:0] rxq[$];
   int lv[4] = '{1, 4, 8, 14};
   ufc_top DUT (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_take(tx_take), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
      .rx_load(rx_load), .rx_char(rx_char), .rx_timeout(rx_timeout), .rx_room(rx_room),
      .tx_ready_pin_n(tx_ready_pin_n), .rx_ready_pin_n(rx_ready_pin_n),
      .rx_data_int(rx_data_int), .tx_int(tx_int), .irq(irq));
   ufc_shifter_model shifter (.sys_clk(sys_clk), .resetn(resetn), .feed(feed), .drain(drain),
      .tmo(tmo), .rx_room(rx_room), .tx_char_valid(tx_char_valid), .rx_load(rx_load),
      .rx_char(rx_char), .rx_timeout(rx_timeout), .tx_take(tx_take));
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string name);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(name, reg_rdata, exp);
   endtask : rdc
   task automatic pop_rx();
      logic [7:0] e;
      e = rxq.pop_front();
      rdc(`UFC_OFS_DATA, e, "rx data");
   endtask : pop_rx
   task automatic push_rx();
      logic ok;
      @(posedge sys_clk);
      feed <= 1'b1;
      #1 ok = rx_room;
      @(posedge sys_clk);
      feed <= 1'b0;
      #1;
      if (ok)
      begin
         rxq.push_back(sent);
         sent++;
      end
   endtask : push_rx
   task automatic pulse_cycle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : pulse_cycle
   task automatic wrap_up();
      $display("comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial
   begin
      #1000000;
      errors++;
      wrap_up();
   end
   initial
   begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      feed = 1'b0;
      drain = 1'b0;
      tmo = 1'b0;
      sent = 8'h00;
      errors = 0;
      comparisons = 0;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      rdc(`UFC_OFS_CTRL, 8'h00, "ctrl after reset");
      chk("tx pin", 8'(tx_ready_pin_n), 8'h00);
      chk("rx pin", 8'(rx_ready_pin_n), 8'h01);
      wr(`UFC_OFS_CTRL, 8'hc8);
      rdc(`UFC_OFS_CTRL, 8'h00, "ctrl without enable");
      for (int c = 0; c < 4; c++)
      begin
         wr(`UFC_OFS_CTRL, {c[1:0], 6'h37});
         rxq.delete();
         pulse_cycle();
         rdc(`UFC_OFS_CTRL, {c[1:0], 6'h01}, "ctrl");
         for (int i = 1; i <= 16; i++)
         begin
            push_rx();
            chk("rx data int", 8'(rx_data_int), 8'(i >= lv[c]));
            chk("rx pin", 8'(rx_ready_pin_n), 8'h00);
         end
         push_rx();
         chk("rx room", 8'(rx_room), 8'h00);
         rdc(`UFC_OFS_RXFILL, 8'h10, "rx fill");
         for (int i = 15; i >= 0; i--)
         begin
            pop_rx();
            chk("rx data int", 8'(rx_data_int), 8'(i >= lv[c]));
         end
         chk("rx pin", 8'(rx_ready_pin_n), 8'h01);
      end
      wr(`UFC_OFS_CTRL, 8'h8f);
      pulse_cycle();
      rdc(`UFC_OFS_CTRL, 8'h89, "ctrl");
      for (int i = 1; i <= 8; i++)
      begin
         push_rx();
         chk("rx pin", 8'(rx_ready_pin_n), 8'h01);
      end
      @(posedge sys_clk);
      #1 chk("rx pin", 8'(rx_ready_pin_n), 8'h00);
      for (int i = 7; i >= 0; i--)
      begin
         pop_rx();
         chk("rx pin", 8'(rx_ready_pin_n), 8'h00);
      end
      @(posedge sys_clk);
      #1 chk("rx pin", 8'(rx_ready_pin_n), 8'h01);
      push_rx();
      chk("rx pin", 8'(rx_ready_pin_n), 8'h01);
      @(posedge sys_clk);
      tmo <= 1'b1;
      @(posedge sys_clk);
      tmo <= 1'b0;
      #1 chk("rx pin", 8'(rx_ready_pin_n), 8'h00);
      pop_rx();
      chk("rx pin", 8'(rx_ready_pin_n), 8'h00);
      @(posedge sys_clk);
      #1 chk("rx pin", 8'(rx_ready_pin_n), 8'h01);
      for (int i = 1; i <= 16; i++)
      begin
         wr(`UFC_OFS_DATA, 8'(i));
         chk("tx pin", 8'(tx_ready_pin_n), 8'(i == 16));
         chk("tx int", 8'(tx_int), 8'(i < 16));
      end
      rdc(`UFC_OFS_TXFILL, 8'h10, "tx fill");
      chk("tx head", tx_char, 8'h01);
      wr(`UFC_OFS_CTRL, 8'h8d);
      pulse_cycle();
      rdc(`UFC_OFS_TXFILL, 8'h00, "tx fill");
      rdc(`UFC_OFS_CTRL, 8'h89, "ctrl");
      wr(`UFC_OFS_CTRL, 8'h01);
      chk("tx pin", 8'(tx_ready_pin_n), 8'h00);
      wr(`UFC_OFS_DATA, 8'h5a);
      chk("tx pin", 8'(tx_ready_pin_n), 8'h01);
      chk("tx head", tx_char, 8'h5a);
      chk("tx valid", 8'(tx_char_valid), 8'h01);
      @(posedge sys_clk);
      drain <= 1'b1;
      @(posedge sys_clk);
      drain <= 1'b0;
      #1 chk("tx pin", 8'(tx_ready_pin_n), 8'h00);
      chk("tx valid", 8'(tx_char_valid), 8'h00);
      repeat (3) push_rx();
      wr(`UFC_OFS_CTRL, 8'h03);
      rxq.delete();
      pulse_cycle();
      rdc(`UFC_OFS_RXFILL, 8'h00, "rx fill");
      rdc(`UFC_OFS_CTRL, 8'h01, "ctrl");
      wr(`UFC_OFS_MASK, 8'h01);
      wr(`UFC_OFS_CTRL, 8'h47);
      rxq.delete();
      pulse_cycle();
      wr(`UFC_OFS_STAT, 8'h0f);
      chk("irq idle", 8'(irq), 8'h00);
      repeat (4) push_rx();
      pulse_cycle();
      chk("irq", 8'(irq), 8'h01);
      wr(`UFC_OFS_MASK, 8'h00);
      chk("irq masked", 8'(irq), 8'h00);
      wr(`UFC_OFS_MASK, 8'h01);
      chk("irq unmasked", 8'(irq), 8'h01);
      wr(`UFC_OFS_STAT, 8'h01);
      chk("irq cleared", 8'(irq), 8'h00);
      rdc(3'h7, 8'h00, "unmapped");
      wr(`UFC_OFS_CTRL, 8'h03);
      rxq.delete();
      pulse_cycle();
      wr(`UFC_OFS_CTRL, 8'h00);
      repeat (2) push_rx();
      rdc(`UFC_OFS_RXFILL, 8'h01, "rx fill off");
      chk("rx room", 8'(rx_room), 8'h00);
      rdc(`UFC_OFS_CTRL, 8'h00, "ctrl off");
      pop_rx();
      wrap_up();
   end
endmodule : testbench

// ---- sim/ufc_shifter_model.sv ----
// behavioural model of the serial shifters beside the fifo control block
`timescale 1ns/1ps
module ufc_shifter_model
   import ufc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic feed,
   input wire logic drain,
   input wire logic tmo,
   input wire logic rx_room,
   input wire logic tx_char_valid,
   output logic rx_load,
   output logic [7:0] rx_char,
   output logic rx_timeout,
   output logic tx_take
);
   logic [7:0] next_r;
   // received characters count up from zero, one per load
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         next_r <= 8'h00;
      else if (rx_load)
         next_r <= next_r + 8'h01;
   end
   // only deliver while there is room, so nothing overruns unless a load falls in the cycle of a receive flush
   assign rx_load = feed & rx_room;
   // between loads the data lines show the inverse of the last character
   assign rx_char = rx_load ? next_r : ~(next_r - 8'h01);
   assign rx_timeout = tmo;
   assign tx_take = drain & tx_char_valid;
endmodule : ufc_shifter_model
